// ---- verilog/mcct_pkg.sv ----
package mcct_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_INST = 4;
  localparam int NUM_WIDE = 2;
  localparam int WIDE_W = 32;
  localparam int NARROW_W = 16;
  localparam int NUM_MATCH = 4;
  localparam int EV_PER_INST = 5;
  localparam int STATUS_W = 20;
  localparam int ADDR_W = 9;
  localparam int INST_LSB = 6;
  localparam int GLOB_BIT = 8;

  // ----------------------------------------------------------------
  // per instance offsets (base = instance << INST_LSB)
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_PRESC = 6'h04;
  localparam logic [5:0] OFF_PCNT = 6'h08;
  localparam logic [5:0] OFF_COUNT = 6'h0C;
  localparam logic [5:0] OFF_MCTL = 6'h10;
  localparam logic [5:0] OFF_ECTL = 6'h14;
  localparam logic [5:0] OFF_MATCH0 = 6'h18;
  localparam int MATCH_STRIDE = 4;
  localparam logic [5:0] OFF_CAPT = 6'h28;

  // ----------------------------------------------------------------
  // global offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] GLOB_STATUS = 9'h100;
  localparam logic [8:0] GLOB_MASK = 9'h104;

  // ----------------------------------------------------------------
  // fields and masks
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLR = 1;
  localparam int CTRL_CNTMODE = 2;
  localparam int CTRL_CAPRISE = 3;
  localparam int CTRL_CAPFALL = 4;
  localparam int CTRL_CAPINT = 5;
  localparam logic [31:0] CTRL_MASK = 32'h0000_003F;
  localparam int MC_INT = 0;
  localparam int MC_RST = 1;
  localparam int MC_STOP = 2;
  localparam int MC_STRIDE = 3;
  localparam logic [31:0] MCTL_MASK = 32'h0000_0FFF;
  localparam int EC_ACT_LSB = 4;
  localparam int EC_STRIDE = 2;
  localparam logic [31:0] ECTL_ACT_MASK = 32'h0000_0FF0;
  localparam logic [31:0] WIDE_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] NARROW_MASK = 32'h0000_FFFF;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic SYNC_RST = 1'b0;

  // ----------------------------------------------------------------
  // match output actions
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

endpackage

// ---- verilog/mcct_sync.sv ----
`timescale 1ns/1ps
module mcct_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  // three stages, level taken once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= mcct_pkg::SYNC_RST;
      s2_q <= mcct_pkg::SYNC_RST;
      s3_q <= mcct_pkg::SYNC_RST;
      out_q <= mcct_pkg::SYNC_RST;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        out_q <= s3_q;
    end
  end

  assign dout = out_q;

endmodule

// ---- verilog/mcct_presc.sv ----
`timescale 1ns/1ps
module mcct_presc #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic tick,
  output logic [W-1:0] pcount
);

  logic [W-1:0] pc_q;
  logic [W-1:0] pc_d;
  logic at_lim;

  // terminal value reached: tick and restart from zero
  assign at_lim = (pc_q == limit);
  assign tick = step & at_lim & ~clr;
  assign pc_d = clr ? '0 : (step ? (at_lim ? '0 : pc_q + 1'b1) : pc_q);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pc_q <= '0;
    else
      pc_q <= pc_d;
  end

  assign pcount = pc_q;

endmodule

// ---- verilog/mcct_top.sv ----
// What this block does
// - four timers: two with 32-bit counts, two with 16-bit counts, same behaviour
// - timer mode counts cycles of the system clock, no other clock
// - each timer has a programmable prescaler as wide as its counter
// - each timer selects timer mode or counting of external input edges
// - four independent match registers compared with the running count
// - a match may leave the counter running and optionally interrupt
// - a match may stop the counter and optionally interrupt
// - a match may reset the counter to zero and optionally interrupt
// - each match drives its output low, high, toggled or unchanged
// - one capture channel copies the count on the selected rising and/or falling edges of its input
// - a capture event raises an interrupt only when enabled
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mcct_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] cap_in,
  input wire logic [3:0] cnt_in,
  output logic [15:0] match_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic [mcct_pkg::STATUS_W-1:0] status_q;
  logic [mcct_pkg::STATUS_W-1:0] status_d;
  logic [mcct_pkg::STATUS_W-1:0] mask_q;
  logic [mcct_pkg::STATUS_W-1:0] stat_clr;
  logic [mcct_pkg::STATUS_W-1:0] ev_all;
  logic [31:0] rd_inst [mcct_pkg::NUM_INST];
  logic [15:0] ext_all;

  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_q;
  wire wr_en = acc & pwrite;
  wire rd_done = acc & ~pwrite;
  wire is_glob = paddr[mcct_pkg::GLOB_BIT];
  wire [1:0] inst = paddr[mcct_pkg::GLOB_BIT-1:mcct_pkg::INST_LSB];
  wire [5:0] roff = paddr[mcct_pkg::INST_LSB-1:0];
  wire hit_status = (paddr == mcct_pkg::GLOB_STATUS);
  wire hit_mask = (paddr == mcct_pkg::GLOB_MASK);

  // ----------------------------------------------------------------
  // offset hits shared by all instances
  // ----------------------------------------------------------------
  logic [mcct_pkg::NUM_MATCH-1:0] moff_hit;

  genvar gm;
  generate
    for (gm = 0; gm < mcct_pkg::NUM_MATCH; gm++)
    begin : g_moff
      assign moff_hit[gm] =
        (roff == 6'(mcct_pkg::OFF_MATCH0 + gm * mcct_pkg::MATCH_STRIDE));
    end
  endgenerate

  wire hit_ctrl = (roff == mcct_pkg::OFF_CTRL);
  wire hit_presc = (roff == mcct_pkg::OFF_PRESC);
  wire hit_pcnt = (roff == mcct_pkg::OFF_PCNT);
  wire hit_count = (roff == mcct_pkg::OFF_COUNT);
  wire hit_mctl = (roff == mcct_pkg::OFF_MCTL);
  wire hit_ectl = (roff == mcct_pkg::OFF_ECTL);
  wire hit_capt = (roff == mcct_pkg::OFF_CAPT);
  wire hit_match = |moff_hit;
  wire [1:0] msel = {moff_hit[3] | moff_hit[2], moff_hit[3] | moff_hit[1]};
  wire inst_hit = hit_ctrl | hit_presc | hit_pcnt | hit_count | hit_mctl
    | hit_ectl | hit_capt | hit_match;
  wire mapped = is_glob ? (hit_status | hit_mask) : inst_hit;
  wire [31:0] glob_rd = hit_status ? 32'(status_q) : (hit_mask ? 32'(mask_q) : 32'h0);
  wire [31:0] rdata = ~mapped ? 32'h0 : (is_glob ? glob_rd : rd_inst[inst]);
  wire rd_stat = rd_done & hit_status;
  wire wr_mask = wr_en & hit_mask;

  // ----------------------------------------------------------------
  // bus answer, one wait-free access phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= mcct_pkg::REG_RST;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup)
        prdata_q <= rdata;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // read clears only bits returned; new events win
  assign stat_clr = rd_stat ? prdata_q[mcct_pkg::STATUS_W-1:0] : '0;
  assign status_d = (status_q & ~stat_clr) | ev_all;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      if (wr_mask)
        mask_q <= pwdata[mcct_pkg::STATUS_W-1:0];
      irq_q <= |(status_q & mask_q);
    end
  end

  assign irq = irq_q;
  assign match_out = ext_all;

  // ----------------------------------------------------------------
  // timer instances
  // ----------------------------------------------------------------
  genvar gi;
  genvar gk;
  generate
    for (gi = 0; gi < mcct_pkg::NUM_INST; gi++)
    begin : g_inst
      localparam int W = (gi < mcct_pkg::NUM_WIDE) ? mcct_pkg::WIDE_W : mcct_pkg::NARROW_W;
      localparam logic [31:0] WMASK =
        (gi < mcct_pkg::NUM_WIDE) ? mcct_pkg::WIDE_MASK : mcct_pkg::NARROW_MASK;

      logic [31:0] ctrl_q;
      logic [31:0] ctrl_d;
      logic [31:0] presc_q;
      logic [31:0] mctl_q;
      logic [31:0] ectl_q;
      logic [31:0] match_q [mcct_pkg::NUM_MATCH];
      logic [W-1:0] cnt_q;
      logic [W-1:0] cnt_d;
      logic [W-1:0] cap_q;
      logic [W-1:0] pcount;
      logic [3:0] ext_q;
      logic [3:0] ext_d;
      logic [3:0] eq;
      logic [3:0] mev;
      logic [3:0] m_int;
      logic [3:0] m_rst;
      logic [3:0] m_stop;
      logic cnt_lvl;
      logic cap_lvl;
      logic cnt_prev_q;
      logic cap_prev_q;
      logic tick;

      wire sel = wr_en & ~is_glob & (inst == 2'(gi));
      wire wr_ctrl = sel & hit_ctrl;
      wire wr_presc = sel & hit_presc;
      wire wr_mctl = sel & hit_mctl;
      wire wr_ectl = sel & hit_ectl;
      wire run = ctrl_q[mcct_pkg::CTRL_RUN];
      wire clr = ctrl_q[mcct_pkg::CTRL_CLR];

      // ----------------------------------------------------------------
      // pin synchronisers and prescaler
      // ----------------------------------------------------------------
      mcct_sync u_sync_cnt (
        .clk(clk),
        .rst(rst),
        .din(cnt_in[gi]),
        .dout(cnt_lvl)
      );

      mcct_sync u_sync_cap (
        .clk(clk),
        .rst(rst),
        .din(cap_in[gi]),
        .dout(cap_lvl)
      );

      wire cnt_rise = cnt_lvl & ~cnt_prev_q;
      // timer mode steps every system clock
      wire step = run & (ctrl_q[mcct_pkg::CTRL_CNTMODE] ? cnt_rise : 1'b1);

      // prescaler as wide as the counter
      mcct_presc #(
        .W(W)
      ) u_presc (
        .clk(clk),
        .rst(rst),
        .clr(clr),
        .step(step),
        .limit(presc_q[W-1:0]),
        .tick(tick),
        .pcount(pcount)
      );

      // ----------------------------------------------------------------
      // match channels
      // ----------------------------------------------------------------
      for (gk = 0; gk < mcct_pkg::NUM_MATCH; gk++)
      begin : g_match
        localparam int MB = gk * mcct_pkg::MC_STRIDE;
        localparam int EB = mcct_pkg::EC_ACT_LSB + gk * mcct_pkg::EC_STRIDE;
        wire [1:0] act = ectl_q[EB+1:EB];
        wire base = wr_ectl ? pwdata[gk] : ext_q[gk];

        assign eq[gk] = (cnt_q == match_q[gk][W-1:0]);
        // match taken on the counting tick
        assign mev[gk] = tick & eq[gk];
        assign m_int[gk] = mctl_q[MB + mcct_pkg::MC_INT];
        assign m_rst[gk] = mctl_q[MB + mcct_pkg::MC_RST];
        assign m_stop[gk] = mctl_q[MB + mcct_pkg::MC_STOP];
        assign ext_d[gk] = ~mev[gk] ? base
          : (act == mcct_pkg::ACT_LOW) ? 1'b0
          : (act == mcct_pkg::ACT_HIGH) ? 1'b1
          : (act == mcct_pkg::ACT_TOGGLE) ? ~ext_q[gk]
          : base;

        always_ff @(posedge clk or posedge rst)
        begin
          if (rst)
            match_q[gk] <= mcct_pkg::REG_RST;
          else if (sel & moff_hit[gk])
            match_q[gk] <= pwdata & WMASK;
        end
      end

      // ----------------------------------------------------------------
      // count and run control
      // ----------------------------------------------------------------
      // reset or stop on match
      wire reset_hit = |(mev & m_rst);
      wire stop_hit = |(mev & m_stop);

      // advance once per prescaler terminal tick
      assign cnt_d = clr ? '0
        : reset_hit ? '0
        : (tick & ~stop_hit) ? cnt_q + 1'b1
        : cnt_q;

      assign ctrl_d = (wr_ctrl ? (pwdata & mcct_pkg::CTRL_MASK) : ctrl_q)
        & ~(32'(stop_hit) << mcct_pkg::CTRL_RUN);

      // ----------------------------------------------------------------
      // capture channel
      // ----------------------------------------------------------------
      // capture on selected input edges
      wire cap_rise = cap_lvl & ~cap_prev_q;
      wire cap_fall = ~cap_lvl & cap_prev_q;
      wire cev = (cap_rise & ctrl_q[mcct_pkg::CTRL_CAPRISE])
        | (cap_fall & ctrl_q[mcct_pkg::CTRL_CAPFALL]);

      assign ev_all[gi*mcct_pkg::EV_PER_INST +: mcct_pkg::EV_PER_INST] =
        {cev & ctrl_q[mcct_pkg::CTRL_CAPINT], mev & m_int};

      // ----------------------------------------------------------------
      // instance registers
      // ----------------------------------------------------------------
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          ctrl_q <= mcct_pkg::REG_RST;
          presc_q <= mcct_pkg::REG_RST;
          mctl_q <= mcct_pkg::REG_RST;
          ectl_q <= mcct_pkg::REG_RST;
          ext_q <= '0;
          cnt_q <= '0;
          cnt_prev_q <= 1'b0;
          cap_prev_q <= 1'b0;
        end
        else
        begin
          ctrl_q <= ctrl_d;
          if (wr_presc)
            presc_q <= pwdata & WMASK;
          if (wr_mctl)
            mctl_q <= pwdata & mcct_pkg::MCTL_MASK;
          if (wr_ectl)
            ectl_q <= pwdata & mcct_pkg::ECTL_ACT_MASK;
          ext_q <= ext_d;
          cnt_q <= cnt_d;
          cnt_prev_q <= cnt_lvl;
          cap_prev_q <= cap_lvl;
        end
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          cap_q <= '0;
        else if (cev)
          cap_q <= cnt_q;
      end

      // ----------------------------------------------------------------
      // register read selection
      // ----------------------------------------------------------------
      wire [31:0] ectl_rd = ectl_q | 32'(ext_q);
      wire [31:0] match_rd = match_q[msel];
      assign rd_inst[gi] = hit_ctrl ? ctrl_q
        : hit_presc ? presc_q
        : hit_pcnt ? 32'(pcount)
        : hit_count ? 32'(cnt_q)
        : hit_mctl ? mctl_q
        : hit_ectl ? ectl_rd
        : hit_match ? match_rd
        : hit_capt ? 32'(cap_q)
        : 32'h0;

      assign ext_all[gi*mcct_pkg::NUM_MATCH +: mcct_pkg::NUM_MATCH] = ext_q;
    end
  endgenerate

endmodule

// ---- tb/mcct_top_props.sv ----
`timescale 1ns/1ps
module mcct_top_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] cap_in,
  input wire logic [3:0] cnt_in,
  input wire logic [15:0] match_out,
  input wire logic irq
);
  // ----
  // bus decode and mask shadow
  // ----
  logic [19:0] mask_q;
  logic [19:0] mask_d;
  wire setup = psel && !penable;
  wire glob_bad = paddr[8] && paddr[7:0] != 8'h00 && paddr[7:0] != 8'h04;
  wire inst_bad = !paddr[8] && paddr[5:0] > 6'h28;
  wire mask_wr = psel && penable && pready && pwrite && paddr == 9'h104;
  assign mask_d = mask_wr ? pwdata[19:0] : mask_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mask_q <= 20'h00000;
    else
      mask_q <= mask_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // properties
  // ----
  AST_READY_AFTER_SETUP:
    assert property (setup |=> pready) else $error("no ready after setup");
  AST_READY_CAUSE:
    assert property (!setup |=> !pready) else $error("ready without setup");
  AST_ERR_GLOBAL:
    assert property (setup && glob_bad |=> pslverr) else $error("global hole accepted");
  AST_ERR_INSTANCE:
    assert property (setup && inst_bad |=> pslverr) else $error("instance hole accepted");
  AST_NO_ERR:
    assert property (setup && !glob_bad && !inst_bad && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
  AST_ERR_DATA:
    assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");
  AST_ERR_READY:
    assert property (pslverr |-> pready) else $error("error without ready");
  AST_IRQ_MASKED:
    assert property (mask_q == 20'h0 && $past(mask_q) == 20'h0 |-> !irq)
      else $error("irq while masked");
  AST_QUIET_RESET:
    assert property ($fell(rst) |-> match_out == 16'h0 && !irq && !pready)
      else $error("outputs not idle after reset");
  cover property ($rose(irq));
  cover property (pslverr);
  cover property ($rose(match_out[0]));
endmodule

bind mcct_top mcct_top_props i_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cap_in(cap_in), .cnt_in(cnt_in), .match_out(match_out), .irq(irq));

// ---- tb/mcct_pins_model.sv ----
`timescale 1ns/1ps
module mcct_pins_model (
  input wire logic clk,
  output logic [3:0] cap_in,
  output logic [3:0] cnt_in
);
  initial
  begin
    cap_in = 4'h0;
    cnt_in = 4'h0;
  end
  task automatic pulses(input int sel, input int cap, input int n, input int hold);
    repeat (n)
    begin
      @(posedge clk);
      if (cap != 0)
        cap_in[sel] <= 1'b1;
      else
        cnt_in[sel] <= 1'b1;
      repeat (hold) @(posedge clk);
      cap_in[sel] <= 1'b0;
      cnt_in[sel] <= 1'b0;
      repeat (hold) @(posedge clk);
    end
  endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [8:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] cap_in;
  logic [3:0] cnt_in;
  logic [15:0] match_out;
  logic irq;
  int fail_count;
  int compares;
  logic [31:0] rv;
  logic [31:0] c1;
  logic ev;
  logic prev;
  logic [1:0] acts [4];
  logic [3:0] mexp;

  mcct_top i_mcct_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cap_in(cap_in), .cnt_in(cnt_in), .match_out(match_out), .irq(irq));
  mcct_pins_model i_mcct_pins_model (.clk(clk), .cap_in(cap_in), .cnt_in(cnt_in));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----
  // helpers
  // ----
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic wr, input logic [8:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(rv, exp);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 300)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  function automatic logic [8:0] ra(input int i, input logic [5:0] off);
    return {1'b0, 2'(i), off};
  endfunction

  // ----
  // sequence
  // ----
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 9'h000;
    pwdata = 32'h0;
    fail_count = 0;
    compares = 0;
    acts = '{mcct_pkg::ACT_HIGH, mcct_pkg::ACT_LOW, mcct_pkg::ACT_TOGGLE, mcct_pkg::ACT_NONE};
    mexp = 4'hD;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ra(0, mcct_pkg::OFF_CTRL), 32'h0);
    rd(9'h108, 32'h0);
    chk1(ev, 1'b1);
    rd(mcct_pkg::GLOB_STATUS, 32'h0);
    chk1(ev, 1'b0);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
      apb(1'b1, ra(0, mcct_pkg::OFF_MATCH0 + 6'(4 * k)), 32'hA5A5_0000 + 32'(k));
    for (int k = 0; k < 4; k++)
      rd(ra(0, mcct_pkg::OFF_MATCH0 + 6'(4 * k)), 32'hA5A5_0000 + 32'(k));
    apb(1'b1, ra(2, mcct_pkg::OFF_MATCH0), 32'hFFFF_FFFF);
    rd(ra(2, mcct_pkg::OFF_MATCH0), 32'h0000_FFFF);
    $display("test registers done");
    apb(1'b1, ra(0, mcct_pkg::OFF_MATCH0), 32'h3);
    apb(1'b1, ra(0, mcct_pkg::OFF_PRESC), 32'h1);
    apb(1'b1, ra(0, mcct_pkg::OFF_MCTL), 32'h5);
    apb(1'b1, mcct_pkg::GLOB_MASK, 32'h1);
    prev = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, ra(0, mcct_pkg::OFF_ECTL), {26'h0, acts[k], 3'h0, prev});
      apb(1'b1, ra(0, mcct_pkg::OFF_CTRL), 32'h2);
      apb(1'b1, ra(0, mcct_pkg::OFF_CTRL), 32'h1);
      wait_irq();
      rd(ra(0, mcct_pkg::OFF_COUNT), 32'h3);
      rd(ra(0, mcct_pkg::OFF_CTRL), 32'h0);
      rd(mcct_pkg::GLOB_STATUS, 32'h1);
      chk32({16'h0, match_out}, {31'h0, mexp[k]});
      prev = mexp[k];
    end
    rd(mcct_pkg::GLOB_STATUS, 32'h0);
    $display("test stop done");
    apb(1'b1, ra(1, mcct_pkg::OFF_MATCH0), 32'h2);
    apb(1'b1, ra(1, mcct_pkg::OFF_MCTL), 32'h3);
    apb(1'b1, ra(1, mcct_pkg::OFF_CTRL), 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, ra(1, mcct_pkg::OFF_COUNT), 32'h0);
      chk1(rv <= 32'h2, 1'b1);
      chk1(irq, 1'b0);
    end
    apb(1'b1, ra(1, mcct_pkg::OFF_CTRL), 32'h0);
    rd(mcct_pkg::GLOB_STATUS, 32'h0000_0020);
    $display("test reset on match done");
    apb(1'b1, ra(3, mcct_pkg::OFF_MATCH0), 32'h4);
    apb(1'b1, ra(3, mcct_pkg::OFF_MCTL), 32'h1);
    apb(1'b1, mcct_pkg::GLOB_MASK, 32'h0008_8000);
    apb(1'b1, ra(3, mcct_pkg::OFF_CTRL), 32'h9);
    wait_irq();
    rd(mcct_pkg::GLOB_STATUS, 32'h0000_8000);
    apb(1'b0, ra(3, mcct_pkg::OFF_COUNT), 32'h0);
    chk1(rv > 32'h4, 1'b1);
    i_mcct_pins_model.pulses(3, 1, 1, 3);
    rd(mcct_pkg::GLOB_STATUS, 32'h0);
    apb(1'b0, ra(3, mcct_pkg::OFF_CAPT), 32'h0);
    c1 = rv;
    chk1(c1 > 32'h4, 1'b1);
    apb(1'b1, ra(3, mcct_pkg::OFF_CTRL), 32'h29);
    i_mcct_pins_model.pulses(3, 1, 1, 3);
    wait_irq();
    rd(mcct_pkg::GLOB_STATUS, 32'h0008_0000);
    apb(1'b0, ra(3, mcct_pkg::OFF_CAPT), 32'h0);
    chk1(rv > c1, 1'b1);
    c1 = rv;
    apb(1'b1, ra(3, mcct_pkg::OFF_CTRL), 32'h31);
    i_mcct_pins_model.pulses(3, 1, 1, 3);
    wait_irq();
    rd(mcct_pkg::GLOB_STATUS, 32'h0008_0000);
    apb(1'b0, ra(3, mcct_pkg::OFF_CAPT), 32'h0);
    chk1(rv > c1, 1'b1);
    $display("test capture done");
    apb(1'b1, ra(2, mcct_pkg::OFF_CTRL), 32'h5);
    i_mcct_pins_model.pulses(2, 0, 3, 6);
    rd(ra(2, mcct_pkg::OFF_COUNT), 32'h3);
    apb(1'b1, ra(2, mcct_pkg::OFF_CTRL), 32'h2);
    apb(1'b1, ra(2, mcct_pkg::OFF_PRESC), 32'h2);
    apb(1'b1, ra(2, mcct_pkg::OFF_CTRL), 32'h5);
    i_mcct_pins_model.pulses(2, 0, 4, 6);
    rd(ra(2, mcct_pkg::OFF_COUNT), 32'h1);
    rd(ra(2, mcct_pkg::OFF_PCNT), 32'h1);
    $display("test counter mode done");
    tally_and_finish();
  end
endmodule
